// ===== rtl/cttc_params.svh
`ifndef CTTC_PARAMS_SVH
`define CTTC_PARAMS_SVH
`define CTTC_STORE_POS   7'd100
`define CTTC_PROG_STEPS  8'd180
`define CTTC_WORD_BITS   6'd48
`define CTTC_REC_WORDS   4'd14
`define CTTC_TOTAL_BITS  10'd672
`define CTTC_BITS_ALPHA  4'd6
`define CTTC_BITS_NUM    4'd4
`define CTTC_BITS_TRANS  4'd12
`define CTTC_FILL_E      4'd12
`define CTTC_FILL_D      4'd8
`define CTTC_FILL_B      4'd4
`define CTTC_IDX_SERIAL  6'd15
`define CTTC_IDX_CTRL    6'd16
`define CTTC_BLK_SECOND  6'd16
`define CTTC_CW_GOOD     48'h4000_0000_0000
`define CTTC_SENT_OP     4'hA
`define CTTC_SENT_C      16'h1983
`define CTTC_BLANK_CODE  6'h30
`define CTTC_RUNID_WT    4'd9
`endif

// ===== rtl/cttc_pkg.sv
`default_nettype none
package cttc_pkg;
   typedef enum logic [2:0] {SK_CONV, SK_FILL12, SK_FILL8, SK_FILL4, SK_END} cttc_kind_t;
   typedef enum logic [3:0] {
      CM_TRANS, CM_ALPHA_BD, CM_ALPHA_BP, CM_NUM_BD, CM_NUM_BP,
      CM_HEX_BD, CM_HEX_BP, CM_SIGN_BD, CM_SIGN_BP
   } cttc_method_t;
   typedef struct packed {
      cttc_kind_t   kind;
      cttc_method_t method;
   } cttc_step_t;
   // Column rows: [11:2] rows 9..0, [1] X, [0] R
   typedef struct packed {
      logic        col_stb;
      logic [6:0]  col_pos;
      logic [11:0] rd1;
      logic [11:0] rd2;
      logic        card_end;
      logic        batch_end;
      logic        tape_ready;
      logic        long_reject;
      logic        restart;
      logic        serial_load;
      logic [47:0] serial_preset;
      logic        runid_en;
      logic [11:0] runid_sw;
   } cttc_pins_t;
   typedef struct packed {
      logic [5:0]  idx;
      logic [47:0] data;
   } cttc_tword_t;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_SHIFT, ST_W15, ST_W16, ST_DONE, ST_HALT}
      cttc_state_t;
endpackage : cttc_pkg
`default_nettype wire

// ===== rtl/cttc_core.sv
`include "cttc_params.svh"
`default_nettype none
module cttc_core (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               prog_we,
   input  wire logic [7:0]         prog_addr,
   input  wire cttc_pkg::cttc_step_t prog_step,
   input  wire cttc_pkg::cttc_pins_t pins,
   output logic                    card_to_stacker,
   output logic                    serial_print_stb,
   output logic [47:0]             serial_print_val,
   output logic                    tape_valid,
   output cttc_pkg::cttc_tword_t   tape_word,
   output logic                    tape_blk_end,
   output logic                    ind_conv_err,
   output logic                    ind_long_tape,
   output logic                    halted,
   output logic                    runid_bad
);
   import cttc_pkg::*;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   cttc_pins_t s1_ff, s2_ff, s3_ff;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else if (ce) begin
         s1_ff <= pins;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   logic col_p, end_p, batch_p, long_p, rst_p, load_p, trdy;
   assign col_p   = s2_ff.col_stb & ~s3_ff.col_stb;
   assign end_p   = s2_ff.card_end & ~s3_ff.card_end;
   assign batch_p = s2_ff.batch_end & ~s3_ff.batch_end;
   assign long_p  = s2_ff.long_reject & ~s3_ff.long_reject;
   assign rst_p   = s2_ff.restart & ~s3_ff.restart;
   assign load_p  = s2_ff.serial_load & ~s3_ff.serial_load;
   assign trdy    = s2_ff.tape_ready;

   // ----------------------------------------
   // Column conversion
   // ----------------------------------------
   function automatic logic [16:0] conv(input cttc_method_t m, input logic [11:0] c);
      logic [3:0] n;
      logic [3:0] num;
      logic       blank;
      logic       multi;
      logic       bd;
      logic [11:0] v;
      logic [3:0]  w;
      n     = 4'd0;
      num   = 4'd0;
      multi = 1'b0;
      for (int i = 0; i < 10; i++) begin
         if (c[i + 2]) begin
            num = 4'(i);
         end
      end
      multi = ($countones(c[11:2]) > 1);
      blank = (c == 12'h000);
      bd    = (m == CM_ALPHA_BD) || (m == CM_NUM_BD) || (m == CM_HEX_BD) ||
              (m == CM_SIGN_BD);
      v = 12'h000;
      case (m)
         CM_TRANS: begin
            n     = `CTTC_BITS_TRANS;
            multi = 1'b0; // Every punch pattern is legal in plain copy
            v     = c;
         end
         CM_ALPHA_BD, CM_ALPHA_BP: begin
            n = `CTTC_BITS_ALPHA;
            v = {6'h00, c[1:0], num};
         end
         CM_NUM_BD, CM_NUM_BP: begin
            n = `CTTC_BITS_NUM;
            blank = (c[11:2] == 10'h000);
            v = {8'h00, num};
         end
         CM_HEX_BD, CM_HEX_BP: begin
            n = `CTTC_BITS_NUM;
            blank = (c[11:2] == 10'h000) && !c[0];
            v = {8'h00, num | {c[0], 3'h0}};
         end
         default: begin
            n = `CTTC_BITS_NUM;
            multi = 1'b0;
            v = {8'h00, 2'b01, c[1], c[0]};
         end
      endcase
      w = n;
      return {(bd && blank) || multi, w, v};
   endfunction : conv

   // ----------------------------------------
   // Staging store and step program
   // ----------------------------------------
   logic [11:0] store_ff [100];
   cttc_step_t  prog_ff  [180];
   cttc_state_t st_ff, nxt_st;
   always_ff @(posedge ref_clk) begin
      if (ce && col_p && st_ff == ST_IDLE && s2_ff.col_pos < `CTTC_STORE_POS) begin
         store_ff[s2_ff.col_pos] <= s2_ff.rd1;
      end
      if (ce && prog_we && prog_addr < `CTTC_PROG_STEPS) begin
         prog_ff[prog_addr] <= prog_step;
      end
   end

   // ----------------------------------------
   // Serial count
   // ----------------------------------------
   logic [47:0] ser_ff, nxt_ser, ser_inc;
   logic [7:0]  cy;
   assign cy[0] = 1'b1;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_dig
         logic [3:0] d;
         assign d = ser_ff[4 * g +: 4];
         assign ser_inc[4 * g +: 4] = !cy[g] ? d : (d == 4'd9) ? 4'd0 : d + 4'd1;
         assign cy[g + 1] = cy[g] && d == 4'd9;
      end
   endgenerate
   assign ser_inc[47:28] = ser_ff[47:28];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic [7:0]  pc_ff, nxt_pc;
   logic [6:0]  colp_ff, nxt_colp;
   logic [11:0] sh_ff, nxt_sh;
   logic [3:0]  shn_ff, nxt_shn;
   logic [47:0] acc_ff, nxt_acc, prt_ff, nxt_prt;
   logic [5:0]  nb_ff, nxt_nb;
   logic [3:0]  widx_ff, nxt_widx;
   logic [9:0]  tb_ff, nxt_tb;
   logic ill_ff, nxt_ill, cerr_ff, nxt_cerr, half_ff, nxt_half, pstb_ff, nxt_pstb;
   logic serr_ff, nxt_serr, slong_ff, nxt_slong, blk_ff, nxt_blk, tv_ff, nxt_tv;
   cttc_tword_t tw_ff, nxt_tw;
   cttc_step_t  stp;
   logic [16:0] cv;
   logic        ofree, stop_any, id_ok;
   logic [5:0]  base;
   logic [47:0] cw16;

   assign stp      = prog_ff[pc_ff];
   assign cv       = conv(stp.method, store_ff[colp_ff]);
   assign ofree    = !tv_ff || trdy;
   assign stop_any = serr_ff || slong_ff;
   assign base     = half_ff ? `CTTC_BLK_SECOND : 6'd0;
   assign id_ok    = s2_ff.runid_en && ($countones(s2_ff.runid_sw) == 32'(`CTTC_RUNID_WT));
   always_comb begin
      cw16 = ill_ff ? {`CTTC_SENT_OP, 12'h000, 16'h0000, `CTTC_SENT_C} : `CTTC_CW_GOOD;
      if (id_ok) begin
         cw16[43:32] = s2_ff.runid_sw;
      end
      if (cerr_ff) begin
         cw16 = {8{`CTTC_BLANK_CODE}};
      end
   end

   always_comb begin
      nxt_st = st_ff;   nxt_pc = pc_ff;   nxt_colp = colp_ff; nxt_sh = sh_ff;
      nxt_shn = shn_ff; nxt_acc = acc_ff; nxt_nb = nb_ff;     nxt_widx = widx_ff;
      nxt_tb = tb_ff;   nxt_ill = ill_ff; nxt_cerr = cerr_ff; nxt_half = half_ff;
      nxt_serr = serr_ff; nxt_slong = slong_ff; nxt_ser = ser_ff; nxt_prt = prt_ff;
      nxt_pstb = 1'b0;  nxt_blk = 1'b0;   nxt_tw = tw_ff;
      nxt_tv = tv_ff && !trdy;
      if (col_p && st_ff == ST_IDLE && s2_ff.rd1 != s2_ff.rd2) begin
         nxt_cerr = 1'b1;
      end
      case (st_ff)
         ST_IDLE: begin
            if (load_p) begin
               nxt_ser = s2_ff.serial_preset;
            end
            if (end_p && !stop_any) begin
               nxt_prt  = ser_ff;
               nxt_pstb = 1'b1;
               nxt_ser  = ser_inc;
               nxt_pc = 8'd0; nxt_colp = 7'd0; nxt_nb = 6'd0;
               nxt_widx = 4'd0; nxt_tb = 10'd0; nxt_acc = 48'h0;
               nxt_st = ST_FETCH;
            end else if (batch_p && half_ff) begin
               nxt_half = 1'b0;
               nxt_blk  = 1'b1;
            end else if (stop_any) begin
               nxt_st = ST_HALT;
            end
         end
         ST_FETCH: begin
            if (nb_ff == `CTTC_WORD_BITS) begin
               if (ofree) begin
                  nxt_tv = 1'b1;
                  nxt_nb = 6'd0;
                  if (widx_ff == `CTTC_REC_WORDS) begin
                     nxt_cerr = 1'b1;
                     nxt_tv   = tv_ff && !trdy;
                  end else begin
                     nxt_widx = widx_ff + 4'd1;
                     nxt_tw   = '{base + {2'b00, widx_ff} + 6'd1, acc_ff};
                  end
               end
            end else if (pc_ff == `CTTC_PROG_STEPS) begin
               nxt_cerr = 1'b1;
               nxt_st   = ST_W15;
            end else begin
               nxt_pc  = pc_ff + 8'd1;
               nxt_st  = ST_SHIFT;
               nxt_sh  = 12'h000;
               case (stp.kind)
                  SK_CONV: begin
                     if (colp_ff == `CTTC_STORE_POS) begin
                        nxt_cerr = 1'b1;
                        nxt_st   = ST_W15;
                     end else begin
                        nxt_colp = colp_ff + 7'd1;
                        nxt_shn  = cv[15:12];
                        nxt_sh   = cv[11:0] << (4'd12 - cv[15:12]);
                        nxt_ill  = ill_ff | cv[16];
                     end
                  end
                  SK_FILL12: nxt_shn = `CTTC_FILL_E;
                  SK_FILL8:  nxt_shn = `CTTC_FILL_D;
                  SK_FILL4:  nxt_shn = `CTTC_FILL_B;
                  default: begin
                     if (tb_ff != `CTTC_TOTAL_BITS) begin
                        nxt_cerr = 1'b1;
                     end
                     nxt_st = ST_W15;
                  end
               endcase
            end
         end
         ST_SHIFT: begin
            if (shn_ff == 4'd0 || nb_ff == `CTTC_WORD_BITS) begin
               nxt_st = ST_FETCH;
            end else begin
               nxt_acc = {acc_ff[46:0], sh_ff[11]};
               nxt_sh  = {sh_ff[10:0], 1'b0};
               nxt_shn = shn_ff - 4'd1;
               nxt_nb  = nb_ff + 6'd1;
               nxt_tb  = tb_ff + 10'd1;
            end
         end
         ST_W15: begin
            if (ofree) begin
               nxt_tv = 1'b1;
               nxt_tw = '{base + `CTTC_IDX_SERIAL, prt_ff};
               nxt_st = ST_W16;
            end
         end
         ST_W16: begin
            if (ofree) begin
               nxt_tv = 1'b1;
               nxt_tw = '{base + `CTTC_IDX_CTRL, cw16};
               nxt_st = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_half = !half_ff;
            nxt_blk  = half_ff;
            nxt_ill  = 1'b0;
            nxt_cerr = 1'b0;
            nxt_serr = serr_ff | cerr_ff;
            nxt_st   = (cerr_ff || stop_any) ? ST_HALT : ST_IDLE;
         end
         ST_HALT: begin
            if (rst_p) begin
               nxt_serr = 1'b0;
               nxt_slong = 1'b0;
               nxt_st = ST_IDLE;
            end
         end
         default: nxt_st = ST_HALT;
      endcase
      // Set wins over a restart in the same cycle
      if (long_p) begin
         nxt_slong = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE; pc_ff <= '0; colp_ff <= '0; sh_ff <= '0; shn_ff <= '0;
         acc_ff <= '0; nb_ff <= '0; widx_ff <= '0; tb_ff <= '0; ill_ff <= 1'b0;
         cerr_ff <= 1'b0; half_ff <= 1'b0; serr_ff <= 1'b0; slong_ff <= 1'b0;
         ser_ff <= '0; prt_ff <= '0; pstb_ff <= 1'b0; blk_ff <= 1'b0;
         tv_ff <= 1'b0; tw_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st; pc_ff <= nxt_pc; colp_ff <= nxt_colp; sh_ff <= nxt_sh;
         shn_ff <= nxt_shn; acc_ff <= nxt_acc; nb_ff <= nxt_nb; widx_ff <= nxt_widx;
         tb_ff <= nxt_tb; ill_ff <= nxt_ill; cerr_ff <= nxt_cerr; half_ff <= nxt_half;
         serr_ff <= nxt_serr; slong_ff <= nxt_slong; ser_ff <= nxt_ser; prt_ff <= nxt_prt;
         pstb_ff <= nxt_pstb; blk_ff <= nxt_blk; tv_ff <= nxt_tv; tw_ff <= nxt_tw;
      end
   end

   assign card_to_stacker  = st_ff != ST_HALT && !stop_any;
   assign serial_print_stb = pstb_ff;
   assign serial_print_val = prt_ff;
   assign tape_valid       = tv_ff;
   assign tape_word        = tw_ff;
   assign tape_blk_end     = blk_ff;
   assign ind_conv_err     = serr_ff;
   assign ind_long_tape    = slong_ff;
   assign halted           = st_ff == ST_HALT;
   assign runid_bad        = s2_ff.runid_en && !id_ok;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n || !ce);
   property p_halt_hold;
      halted && !rst_p |=> halted;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt left without restart");
   property p_high_fixed;
      pstb_ff |-> ser_ff[47:28] == prt_ff[47:28];
   endproperty
   a_high_fixed: assert property (p_high_fixed) else $error("high digits moved");
   property p_inc;
      st_ff == ST_IDLE && end_p && !stop_any |=> ser_ff == $past(ser_inc) && pstb_ff;
   endproperty
   a_inc: assert property (p_inc) else $error("serial not advanced");
   property p_no_count;
      stop_any && end_p |=> $stable(ser_ff) && !pstb_ff;
   endproperty
   a_no_count: assert property (p_no_count) else $error("rejected card numbered");
   property p_mismatch;
      col_p && st_ff == ST_IDLE && s2_ff.rd1 != s2_ff.rd2 |=> cerr_ff;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("read mismatch missed");
   property p_blank;
      st_ff == ST_W16 && ofree && cerr_ff |=> tw_ff.data == {8{`CTTC_BLANK_CODE}};
   endproperty
   a_blank: assert property (p_blank) else $error("error word not blank");
   property p_serial_w;
      st_ff == ST_W15 && ofree |=> tv_ff && tw_ff.data == prt_ff && tw_ff.idx[3:0] == 4'hF;
   endproperty
   a_serial_w: assert property (p_serial_w) else $error("serial word wrong");
   property p_bits;
      st_ff == ST_FETCH && nb_ff != `CTTC_WORD_BITS && pc_ff != `CTTC_PROG_STEPS &&
      stp.kind == SK_END && tb_ff != `CTTC_TOTAL_BITS |=> cerr_ff && st_ff == ST_W15;
   endproperty
   a_bits: assert property (p_bits) else $error("bit total unchecked");
   property p_col_step;
      st_ff == ST_FETCH && nb_ff != `CTTC_WORD_BITS && pc_ff != `CTTC_PROG_STEPS &&
      stp.kind == SK_CONV && colp_ff != `CTTC_STORE_POS |=> colp_ff == $past(colp_ff) + 7'd1;
   endproperty
   a_col_step: assert property (p_col_step) else $error("column not consumed");
   property p_err_halt;
      st_ff == ST_DONE && cerr_ff |=> halted && ind_conv_err;
   endproperty
   a_err_halt: assert property (p_err_halt) else $error("no stop on error");
   c_blk:  cover property (blk_ff);
   c_err:  cover property (st_ff == ST_DONE && cerr_ff);
   c_long: cover property (halted && slong_ff);
   c_ill:  cover property (st_ff == ST_W16 && ill_ff && !cerr_ff);
endmodule : cttc_core
`default_nettype wire

// ===== bench/cttc_tape_model.sv
`default_nettype none
module cttc_tape_model (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  slow,
   input  wire logic                  tape_valid,
   input  wire cttc_pkg::cttc_tword_t tape_word,
   input  wire logic                  tape_blk_end,
   output logic                       tape_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   import cttc_pkg::*;
   logic [47:0] mem [0:63];
   int          n_words = 0;
   int          n_blk   = 0;
   logic [2:0]  cnt_ff;
   logic        vld_ff;
   cttc_tword_t last_ff;
   // Half-rate stall in slow mode, so words queue inside the block
   assign tape_ready = slow ? cnt_ff[2] : 1'b1;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 3'h0;
         vld_ff <= 1'b0;
      end else begin
         cnt_ff  <= cnt_ff + 3'h1;
         vld_ff  <= tape_valid;
         last_ff <= tape_word;
         // Log a word on first offer; a held word repeats unchanged
         if (tape_valid && (!vld_ff || tape_word != last_ff)) begin
            mem[tape_word.idx] <= tape_word.data;
            n_words            <= n_words + 1;
         end
         if (tape_blk_end) n_blk <= n_blk + 1;
      end
   end
endmodule : cttc_tape_model
`default_nettype wire

// ===== bench/test_card_to_tape_record_converter.sv
`default_nettype none
module test_card_to_tape_record_converter;
   timeunit 1ns;
   timeprecision 1ns;
   import cttc_pkg::*;
   typedef struct packed {
      cttc_method_t m;
      logic [1:0]   k;
      logic [11:0]  rd;
      logic [11:0]  ex;
      logic         ck;
      logic [1:0]   cw;
   } cttc_row_t;
   localparam logic [47:0] CWV [3] = '{48'h4000_0000_0000, 48'hA000_0000_1983,
                                        48'hC30C_30C3_0C30};
   localparam logic [47:0] PRESET = 48'h0012_3999_9998;
   cttc_row_t rows [11] = '{
      '{CM_TRANS,    2'h1, 12'h082, 12'h082, 1'b1, 2'h0},
      '{CM_ALPHA_BD, 2'h2, 12'h082, 12'h965, 1'b1, 2'h0},
      '{CM_ALPHA_BP, 2'h2, 12'h201, 12'h5D7, 1'b1, 2'h0},
      '{CM_NUM_BD,   2'h3, 12'h803, 12'h999, 1'b1, 2'h0},
      '{CM_NUM_BD,   2'h3, 12'h000, 12'h000, 1'b0, 2'h1},
      '{CM_NUM_BP,   2'h3, 12'h000, 12'h000, 1'b1, 2'h0},
      '{CM_HEX_BD,   2'h3, 12'h011, 12'hAAA, 1'b1, 2'h0},
      '{CM_HEX_BP,   2'h3, 12'h020, 12'h333, 1'b1, 2'h0},
      '{CM_SIGN_BD,  2'h3, 12'h002, 12'h666, 1'b1, 2'h0},
      '{CM_SIGN_BP,  2'h3, 12'h003, 12'h777, 1'b1, 2'h0},
      '{CM_ALPHA_BP, 2'h2, 12'h0C0, 12'h000, 1'b0, 2'h1}};
   logic        ref_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        prog_we   = 1'b0;
   logic [7:0]  prog_addr = 8'h00;
   cttc_step_t  prog_step = '0;
   cttc_pins_t  pins_d    = '0;
   cttc_pins_t  pins_c;
   logic        slow      = 1'b0;
   logic        ce        = 1'b1;
   logic        tape_rdy, card_to_stacker, serial_print_stb, tape_valid, tape_blk_end;
   logic        ind_conv_err, ind_long_tape, halted, runid_bad;
   logic [47:0] serial_print_val;
   cttc_tword_t tape_word;
   int          bad_count = 0;
   int          n_tests   = 0;
   int          cyc       = 0;
   int          n_prints  = 0;
   int          base      = 0;
   logic [47:0] last_print;
   logic [47:0] exp_ser   = PRESET;

   always #25 ref_clk = ~ref_clk;
   always_comb begin
      pins_c            = pins_d;
      pins_c.tape_ready = tape_rdy;
   end
   always @(posedge ref_clk) begin
      if (serial_print_stb === 1'b1) begin
         n_prints++;
         last_print = serial_print_val;
      end
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end

   cttc_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_step(prog_step), .pins(pins_c),
      .card_to_stacker(card_to_stacker), .serial_print_stb(serial_print_stb),
      .serial_print_val(serial_print_val), .tape_valid(tape_valid), .tape_word(tape_word),
      .tape_blk_end(tape_blk_end), .ind_conv_err(ind_conv_err),
      .ind_long_tape(ind_long_tape), .halted(halted), .runid_bad(runid_bad));
   cttc_tape_model far (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
      .tape_valid(tape_valid), .tape_word(tape_word), .tape_blk_end(tape_blk_end),
      .tape_ready(tape_rdy));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop

   function automatic logic [47:0] inc7(input logic [47:0] v);
      logic [47:0] r;
      logic        cy;
      r  = v;
      cy = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (cy) begin
            cy         = (r[4*i+:4] == 4'h9);
            r[4*i+:4] = cy ? 4'h0 : r[4*i+:4] + 4'h1;
         end
      end
      return r;
   endfunction : inc7

   // Slow pin edges: the block syncs through two flops
   task automatic pls(input int f);
      @(posedge ref_clk);
      case (f)
         0: pins_d.card_end <= 1'b1;
         1: pins_d.batch_end <= 1'b1;
         2: pins_d.long_reject <= 1'b1;
         3: pins_d.restart <= 1'b1;
         default: pins_d.serial_load <= 1'b1;
      endcase
      repeat (4) @(posedge ref_clk);
      pins_d.card_end    <= 1'b0;
      pins_d.batch_end   <= 1'b0;
      pins_d.long_reject <= 1'b0;
      pins_d.restart     <= 1'b0;
      pins_d.serial_load <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : pls

   task automatic col(input logic [6:0] pos, input logic [11:0] a, input logic [11:0] b);
      @(posedge ref_clk);
      pins_d.col_pos <= pos;
      pins_d.rd1     <= a;
      pins_d.rd2     <= b;
      repeat (4) @(posedge ref_clk);
      pins_d.col_stb <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins_d.col_stb <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : col

   // k conversions, 8 and 4 bit fillers, nf 12 bit fillers, terminator
   task automatic prog(input cttc_method_t m, input int k, input int nf);
      for (int i = 0; i < k + nf + 3; i++) begin
         @(posedge ref_clk);
         prog_we          <= 1'b1;
         prog_addr        <= 8'(i);
         prog_step.method <= m;
         prog_step.kind   <= (i < k) ? SK_CONV : (i == k) ? SK_FILL8 : (i == k + 1) ? SK_FILL4 :
                             (i == k + nf + 2) ? SK_END : SK_FILL12;
      end
      @(posedge ref_clk);
      prog_we <= 1'b0;
   endtask : prog

   task automatic run_card(input cttc_row_t r, input logic [11:0] rd2v, input int nf,
                           input logic [47:0] ctl, input logic lr);
      int w0;
      int p0;
      prog(r.m, int'(r.k), nf);
      for (int c = 0; c < int'(r.k); c++) begin
         col(7'(c), r.rd, (c == 0) ? rd2v : r.rd);
      end
      w0 = far.n_words;
      p0 = n_prints;
      pls(0);
      if (lr) begin
         pls(2);
         chk(48'(card_to_stacker), 48'h0);
      end
      for (int c = 0; c < 6000 && far.n_words < w0 + 16 && halted !== 1'b1; c++)
         @(posedge ref_clk);
      chk(48'(n_prints), 48'(p0 + 1));
      chk(last_print, exp_ser);
      chk(far.mem[base+15], exp_ser);
      chk(far.mem[base+16], ctl);
      if (r.ck) chk(far.mem[base+1], {r.ex, 36'h0});
      for (int w = 2; w < 15; w++) chk(far.mem[base+w], 48'h0);
      exp_ser = inc7(exp_ser);
      base    = 16 - base;
   endtask : run_card

   task automatic stop_chk(input logic [1:0] ind);
      int w0;
      int p0;
      for (int c = 0; c < 3000 && halted !== 1'b1; c++) @(posedge ref_clk);
      chk(48'(halted), 48'h1);
      chk(48'({ind_conv_err, ind_long_tape}), 48'(ind));
      chk(48'(card_to_stacker), 48'h0);
      w0 = far.n_words;
      p0 = n_prints;
      pls(0);
      repeat (20) @(posedge ref_clk);
      chk(48'(n_prints), 48'(p0));
      chk(48'(far.n_words), 48'(w0));
      chk(48'(halted), 48'h1);
      pls(3);
      chk(48'({halted, ind_conv_err, ind_long_tape, card_to_stacker}), 48'h1);
   endtask : stop_chk

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pins_d.serial_preset <= PRESET;
      repeat (2) @(posedge ref_clk);
      chk(48'({card_to_stacker, tape_valid, tape_blk_end, serial_print_stb, ind_conv_err,
               ind_long_tape, halted, runid_bad}), 48'h80);
      rst_n <= 1'b1;
      pls(4);
      for (int i = 0; i < 11; i++) begin
         slow <= i[0];
         run_card(rows[i], rows[i].rd, 54, CWV[rows[i].cw], 1'b0);
      end
      chk(48'(far.n_blk), 48'h5);
      pls(1);
      chk(48'(far.n_blk), 48'h6);
      // Batch end closes the block, so the next card starts a fresh one
      base = 0;
      // Frozen clock enable: a card end pulse must go unseen
      ce <= 1'b0;
      pls(0);
      ce <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(48'(n_prints), 48'd11);
      pins_d.runid_en <= 1'b1;
      pins_d.runid_sw <= 12'h1FF;
      run_card(rows[0], rows[0].rd, 54, 48'h41FF_0000_0000, 1'b0);
      chk(48'(runid_bad), 48'h0);
      pins_d.runid_en <= 1'b0;
      run_card(rows[4], 12'h004, 54, CWV[2], 1'b0);
      stop_chk(2'b10);
      pins_d.runid_en <= 1'b1;
      pins_d.runid_sw <= 12'h0FF;
      run_card(rows[1], rows[1].rd, 54, CWV[0], 1'b0);
      chk(48'(runid_bad), 48'h1);
      pins_d.runid_en <= 1'b0;
      slow            <= 1'b0;
      run_card(rows[0], rows[0].rd, 50, CWV[2], 1'b0);
      stop_chk(2'b10);
      run_card(rows[0], rows[0].rd, 54, CWV[0], 1'b1);
      stop_chk(2'b01);
      report_and_stop();
   end
endmodule : test_card_to_tape_record_converter
`default_nettype wire
